/* logic/wfd_pkg.sv */
// Shared constants and types of the wake frame detector
package wfd_pkg;
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_BASIC_CONTROL = 16'h0000;
	localparam logic [15:0] IDX_INT_ENABLE = 16'h0012;
	localparam logic [15:0] IDX_INT_STATUS = 16'h0013;
	localparam logic [15:0] IDX_WAKE_CONTROL = 16'h4000;
	localparam logic [15:0] IDX_WAKE_MODE = 16'h4003;
	localparam logic [15:0] IDX_ADDR_LOW = 16'h4004;
	localparam logic [15:0] IDX_ADDR_MID = 16'h4005;
	localparam logic [15:0] IDX_ADDR_HIGH = 16'h4006;
	localparam logic [15:0] IDX_EVT_STATUS = 16'h4020;
	localparam logic [15:0] IDX_EVT_MASK = 16'h4021;
	// Field positions
	localparam int BIT_MAC_PORT_ISOLATION = 10;
	localparam int BIT_WAKE_IRQ = 6;
	localparam int BIT_WAKE_EN = 2;
	localparam int BIT_PULSE_MODE = 7;
	localparam int BIT_WIDTH_LO = 8;
	localparam int EVT_WAKE = 0;
	localparam int EVT_REJECT = 1;
	// Reset values
	localparam logic [15:0] RST_REG16 = 16'h0000;
	localparam logic [1:0] RST_EVT = 2'h0;
	// Frame pattern figures
	localparam logic [7:0] SYNC_BYTE = 8'hFF;
	localparam logic [2:0] SYNC_LEN = 3'h6;
	localparam logic [2:0] ADDR_LAST = 3'h5;
	localparam logic [3:0] REP_LAST = 4'hF;
	localparam logic [10:0] MIN_FRAME = 11'h040;
	// Timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int PULSE_UNIT_NS = 64;
	localparam int PULSE_UNIT_CYC = (PULSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {
		SCAN_SYNC,
		SCAN_ADDR
	} wfd_scan_t;
endpackage

/* logic/wfd_sync.sv */
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module wfd_sync #(
	parameter int W = 1
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [W-1:0] d, // Asynchronous inputs
	output logic [W-1:0] q // Synchronised outputs
);
	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

/* logic/wfd_pulse.sv */
// Programmable width pulse timer for the wake indication
`timescale 1ns/1ps
module wfd_pulse #(
	parameter int CW = 8
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic start, // Restart the pulse
	input wire logic [1:0] width_sel, // Width code
	output logic busy // High while the pulse runs
);
	logic [CW-1:0] count;
	logic [CW-1:0] width;

	// Width doubles with each code step
	always_comb begin
		width = CW'(wfd_pkg::PULSE_UNIT_CYC) << width_sel;
	end

	// Down counter; a new start restarts the full width
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
			busy <= 1'b0;
		end else if (start) begin
			count <= width - CW'(1);
			busy <= 1'b1;
		end else begin
			if (count != '0) begin
				count <= count - CW'(1);
			end
			busy <= (count != '0);
		end
	end
endmodule

/* logic/wfd_top.sv */
// Wake frame detector with AXI4-Lite registers and MAC-side isolation
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module wfd_top #(
	parameter int AW = 18
) (
	input wire logic aclk, // Clock, 125 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [AW-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [AW-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic rx_byte_valid, // Received byte strobe
	input wire logic [7:0] rx_byte, // Received byte
	input wire logic rx_frame_end, // End of frame pulse
	input wire logic rx_crc_ok, // Frame check good, with end pulse
	input wire logic [3:0] rx_nibble_in, // Receive nibble to MAC
	input wire logic rx_dv_in, // Receive valid to MAC
	output logic [3:0] mac_rxd, // MAC receive data pins
	output logic mac_rx_dv, // MAC receive valid pin
	output logic mac_rx_oe, // Output enable of MAC pins
	input wire logic [3:0] mac_txd, // MAC transmit data pins
	input wire logic mac_tx_en, // MAC transmit enable pin
	output logic [3:0] tx_nibble_out, // Transmit nibble to core
	output logic tx_en_out, // Transmit enable to core
	input wire logic wake_strap_pad, // Strap pad level
	input wire logic led_state_in, // LED drive from status logic
	output logic first_led_pin, // LED or wake indication, active low wake
	output logic general_phy_irq_out, // General PHY interrupt, active low
	output logic irq // Event interrupt, active high
);
	typedef struct packed {
		logic [15:0] basic_control;
		logic [15:0] int_enable;
		logic [15:0] int_status;
		logic [15:0] wake_control;
		logic [15:0] wake_mode;
		logic [15:0] addr_low;
		logic [15:0] addr_mid;
		logic [15:0] addr_high;
		logic [1:0] evt_status;
		logic [1:0] evt_mask;
		logic aw_got;
		logic [15:0] aw_idx;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		wfd_pkg::wfd_scan_t scan;
		logic [2:0] ff_run;
		logic [2:0] byte_idx;
		logic [3:0] rep;
		logic found;
		logic [10:0] len;
		logic [1:0] strap_wait;
		logic strap_wake;
		logic wake_level;
		logic wake_irq_n;
		logic gen_irq_n;
		logic led;
		logic irq;
		logic [3:0] mac_rxd;
		logic mac_rx_dv;
		logic mac_rx_oe;
		logic [3:0] tx_nibble;
		logic tx_en;
	} wfd_state_t;

	wfd_state_t r;
	wfd_state_t n;
	logic [5:0] pins_sync;
	logic pulse_busy;
	logic wake_event;

	// Index is decoded the same way for reads and writes
	function automatic logic reg_known(input logic [15:0] idx);
		reg_known = (idx == wfd_pkg::IDX_BASIC_CONTROL) || (idx == wfd_pkg::IDX_INT_ENABLE) ||
			(idx == wfd_pkg::IDX_INT_STATUS) || (idx == wfd_pkg::IDX_WAKE_CONTROL) ||
			(idx == wfd_pkg::IDX_WAKE_MODE) || (idx == wfd_pkg::IDX_ADDR_LOW) ||
			(idx == wfd_pkg::IDX_ADDR_MID) || (idx == wfd_pkg::IDX_ADDR_HIGH) ||
			(idx == wfd_pkg::IDX_EVT_STATUS) || (idx == wfd_pkg::IDX_EVT_MASK);
	endfunction

	// Byte lanes of a 16-bit register
	function automatic logic [15:0] apply_strb(input logic [15:0] old, input logic [31:0] d,
			input logic [3:0] s);
		apply_strb = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// address registers, bytes in transmission order
	function automatic logic [7:0] addr_byte(input wfd_state_t s, input logic [2:0] i);
		unique case (i)
			3'h0: addr_byte = s.addr_low[7:0];
			3'h1: addr_byte = s.addr_low[15:8];
			3'h2: addr_byte = s.addr_mid[7:0];
			3'h3: addr_byte = s.addr_mid[15:8];
			3'h4: addr_byte = s.addr_high[7:0];
			default: addr_byte = s.addr_high[15:8];
		endcase
	endfunction

	// Pin inputs pass two flops before use
	wfd_sync #(
		.W(6)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d({wake_strap_pad, mac_tx_en, mac_txd}),
		.q(pins_sync)
	);

	wfd_pulse #(
		.CW(8)
	) u_pulse (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(wake_event && r.wake_mode[wfd_pkg::BIT_PULSE_MODE]),
		.width_sel(r.wake_mode[wfd_pkg::BIT_WIDTH_LO+1:wfd_pkg::BIT_WIDTH_LO]),
		.busy(pulse_busy)
	);

	// frame qualifies only with good CRC and minimum length
	always_comb begin
		wake_event = rx_frame_end && r.found && rx_crc_ok && (r.len >= wfd_pkg::MIN_FRAME) &&
			r.wake_control[wfd_pkg::BIT_WAKE_EN];
	end

	// Next state: bus slave, scanner, interrupts and pins
	always_comb begin
		logic [7:0] exp_byte;
		logic rd_take;
		logic [15:0] ar_idx;
		exp_byte = addr_byte(r, r.byte_idx);
		ar_idx = s_axi_araddr[17:2];
		rd_take = s_axi_arvalid && r.arready;
		n = r;

		// Write address and data are taken in either order
		if (s_axi_awvalid && r.awready) begin
			n.aw_got = 1'b1;
			n.aw_idx = s_axi_awaddr[17:2];
		end
		if (s_axi_wvalid && r.wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_got && r.w_got && !r.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = reg_known(r.aw_idx) ? wfd_pkg::RESP_OKAY : wfd_pkg::RESP_SLVERR;
			unique case (r.aw_idx)
				wfd_pkg::IDX_BASIC_CONTROL: n.basic_control = apply_strb(r.basic_control,
					r.wdata, r.wstrb);
				wfd_pkg::IDX_INT_ENABLE: n.int_enable = apply_strb(r.int_enable, r.wdata, r.wstrb);
				wfd_pkg::IDX_WAKE_CONTROL: n.wake_control = apply_strb(r.wake_control,
					r.wdata, r.wstrb);
				wfd_pkg::IDX_WAKE_MODE: n.wake_mode = apply_strb(r.wake_mode, r.wdata, r.wstrb);
				wfd_pkg::IDX_ADDR_LOW: n.addr_low = apply_strb(r.addr_low, r.wdata, r.wstrb);
				wfd_pkg::IDX_ADDR_MID: n.addr_mid = apply_strb(r.addr_mid, r.wdata, r.wstrb);
				wfd_pkg::IDX_ADDR_HIGH: n.addr_high = apply_strb(r.addr_high, r.wdata, r.wstrb);
				wfd_pkg::IDX_EVT_MASK: n.evt_mask = r.wstrb[0] ? r.wdata[1:0] : r.evt_mask;
				wfd_pkg::IDX_EVT_STATUS: n.evt_status = r.wstrb[0] ?
					(r.evt_status & ~r.wdata[1:0]) : r.evt_status;
				default: n.bresp = n.bresp; // Unmapped or read-only: no store
			endcase
		end

		// Read channel; one read outstanding
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (rd_take) begin
			n.rvalid = 1'b1;
			n.rresp = reg_known(ar_idx) ? wfd_pkg::RESP_OKAY : wfd_pkg::RESP_SLVERR;
			unique case (ar_idx)
				wfd_pkg::IDX_BASIC_CONTROL: n.rdata = {16'h0000, r.basic_control};
				wfd_pkg::IDX_INT_ENABLE: n.rdata = {16'h0000, r.int_enable};
				wfd_pkg::IDX_INT_STATUS: n.rdata = {16'h0000, r.int_status};
				wfd_pkg::IDX_WAKE_CONTROL: n.rdata = {16'h0000, r.wake_control};
				wfd_pkg::IDX_WAKE_MODE: n.rdata = {16'h0000, r.wake_mode};
				wfd_pkg::IDX_ADDR_LOW: n.rdata = {16'h0000, r.addr_low};
				wfd_pkg::IDX_ADDR_MID: n.rdata = {16'h0000, r.addr_mid};
				wfd_pkg::IDX_ADDR_HIGH: n.rdata = {16'h0000, r.addr_high};
				wfd_pkg::IDX_EVT_STATUS: n.rdata = {30'h00000000, r.evt_status};
				wfd_pkg::IDX_EVT_MASK: n.rdata = {30'h00000000, r.evt_mask};
				default: n.rdata = 32'h00000000;
			endcase
		end

		if (rd_take && (ar_idx == wfd_pkg::IDX_INT_STATUS)) begin
			n.int_status[wfd_pkg::BIT_WAKE_IRQ] = 1'b0;
		end
		// A wake in the same cycle as the read wins over the clear
		if (wake_event) begin
			n.int_status[wfd_pkg::BIT_WAKE_IRQ] = 1'b1;
		end

		// byte scanner, restarted for each frame
		if (rx_byte_valid) begin
			n.len = (r.len == 11'h7FF) ? r.len : r.len + 11'h001;
			unique case (r.scan)
				wfd_pkg::SCAN_SYNC: begin
					if (rx_byte == wfd_pkg::SYNC_BYTE) begin
						n.ff_run = (r.ff_run == wfd_pkg::SYNC_LEN) ? r.ff_run : r.ff_run + 3'h1;
					end else if (r.ff_run == wfd_pkg::SYNC_LEN && rx_byte == addr_byte(r, 3'h0)) begin
						n.scan = wfd_pkg::SCAN_ADDR;
						n.byte_idx = 3'h1;
						n.rep = 4'h0;
					end else begin
						n.ff_run = 3'h0;
					end
				end
				wfd_pkg::SCAN_ADDR: begin
					if (rx_byte != exp_byte) begin
						n.scan = wfd_pkg::SCAN_SYNC;
						n.ff_run = (rx_byte == wfd_pkg::SYNC_BYTE) ? 3'h1 : 3'h0;
					end else if (r.byte_idx != wfd_pkg::ADDR_LAST) begin
						n.byte_idx = r.byte_idx + 3'h1;
					end else if (r.rep != wfd_pkg::REP_LAST) begin
						n.byte_idx = 3'h0;
						n.rep = r.rep + 4'h1;
					end else begin
						n.found = 1'b1;
						n.scan = wfd_pkg::SCAN_SYNC;
						n.ff_run = 3'h0;
					end
				end
			endcase
		end
		// disabled or frame over: scanner back to idle
		if (rx_frame_end || !r.wake_control[wfd_pkg::BIT_WAKE_EN]) begin
			n.scan = wfd_pkg::SCAN_SYNC;
			n.ff_run = 3'h0;
			n.byte_idx = 3'h0;
			n.rep = 4'h0;
			n.found = 1'b0;
			n.len = 11'h000;
		end

		// level latches until detection is disabled
		if (!r.wake_control[wfd_pkg::BIT_WAKE_EN]) begin
			n.wake_level = 1'b0;
		end
		if (wake_event && !r.wake_mode[wfd_pkg::BIT_PULSE_MODE]) begin
			n.wake_level = 1'b1;
		end
		n.wake_irq_n = r.wake_mode[wfd_pkg::BIT_PULSE_MODE] ? !pulse_busy : !r.wake_level;
		// wired-AND; level mode cannot be read-cleared
		n.gen_irq_n = !(r.int_enable[wfd_pkg::BIT_WAKE_IRQ] &&
			(r.wake_mode[wfd_pkg::BIT_PULSE_MODE] ? r.int_status[wfd_pkg::BIT_WAKE_IRQ] :
			r.wake_level));

		// Sticky events, write one to clear, set wins
		if (wake_event) begin
			n.evt_status[wfd_pkg::EVT_WAKE] = 1'b1;
		end
		if (rx_frame_end && r.found && !wake_event) begin
			n.evt_status[wfd_pkg::EVT_REJECT] = 1'b1;
		end
		n.irq = |(r.evt_status & r.evt_mask);

		// strap caught once synchroniser has settled after reset
		if (r.strap_wait != 2'h3) begin
			n.strap_wait = r.strap_wait + 2'h1;
			n.strap_wake = pins_sync[5];
		end
		n.led = r.strap_wake ? r.wake_irq_n : led_state_in;

		// isolation floats MAC outputs and drops MAC inputs
		n.mac_rx_oe = !r.basic_control[wfd_pkg::BIT_MAC_PORT_ISOLATION];
		n.mac_rxd = r.basic_control[wfd_pkg::BIT_MAC_PORT_ISOLATION] ? 4'h0 : rx_nibble_in;
		n.mac_rx_dv = r.basic_control[wfd_pkg::BIT_MAC_PORT_ISOLATION] ? 1'b0 : rx_dv_in;
		n.tx_nibble = r.basic_control[wfd_pkg::BIT_MAC_PORT_ISOLATION] ? 4'h0 : pins_sync[3:0];
		n.tx_en = r.basic_control[wfd_pkg::BIT_MAC_PORT_ISOLATION] ? 1'b0 : pins_sync[4];

		// Ready flags registered so every output comes from a flop
		n.awready = !n.aw_got && !n.bvalid;
		n.wready = !n.w_got && !n.bvalid;
		n.arready = !n.rvalid;
	end

	// State register; reset puts everything at its idle value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r <= '0;
			r.basic_control <= wfd_pkg::RST_REG16;
			r.int_enable <= wfd_pkg::RST_REG16;
			r.int_status <= wfd_pkg::RST_REG16;
			r.wake_control <= wfd_pkg::RST_REG16;
			r.wake_mode <= wfd_pkg::RST_REG16;
			r.evt_status <= wfd_pkg::RST_EVT;
			r.evt_mask <= wfd_pkg::RST_EVT;
			r.scan <= wfd_pkg::SCAN_SYNC;
			r.wake_irq_n <= 1'b1;
			r.gen_irq_n <= 1'b1;
			r.led <= 1'b0;
		end else begin
			r <= n;
		end
	end

	// Port drives
	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = r.arready;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rdata = r.rdata;
	assign mac_rxd = r.mac_rxd;
	assign mac_rx_dv = r.mac_rx_dv;
	assign mac_rx_oe = r.mac_rx_oe;
	assign tx_nibble_out = r.tx_nibble;
	assign tx_en_out = r.tx_en;
	assign first_led_pin = r.led;
	assign general_phy_irq_out = r.gen_irq_n;
	assign irq = r.irq;
endmodule

/* test/wfd_properties.sv */
// Port checker of the wake frame detector, bound to its top
`timescale 1ns/1ps
module wfd_chk #(
	parameter int AW = 18
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, low
	input wire logic s_axi_awvalid, // Aw valid
	input wire logic s_axi_awready, // Aw ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic [1:0] s_axi_bresp, // B code
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_bready, // B ready
	input wire logic s_axi_arvalid, // Ar valid
	input wire logic s_axi_arready, // Ar ready
	input wire logic [31:0] s_axi_rdata, // R data
	input wire logic [1:0] s_axi_rresp, // R code
	input wire logic s_axi_rvalid, // R valid
	input wire logic s_axi_rready, // R ready
	input wire logic rx_frame_end, // Frame end
	input wire logic [3:0] rx_nibble_in, // Rx nibble
	input wire logic rx_dv_in, // Rx valid
	input wire logic [3:0] mac_rxd, // MAC data
	input wire logic mac_rx_dv, // MAC valid
	input wire logic mac_rx_oe, // MAC enable
	input wire logic tx_en_out, // Tx enable
	input wire logic first_led_pin, // LED or wake
	input wire logic general_phy_irq_out, // General irq
	input wire logic irq // Event irq
);
	logic [3:0] since_wr;
	logic [3:0] since_ev;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Age of the last write and of the last frame end or read; saturate so they never wrap
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			since_wr <= 4'hF;
			since_ev <= 4'hF;
		end else begin
			since_wr <= s_axi_wvalid && s_axi_wready ? 4'h0 : since_wr + 4'(since_wr != 4'hF);
			since_ev <= rx_frame_end || s_axi_arvalid && s_axi_arready ? 4'h0 :
				since_ev + 4'(since_ev != 4'hF);
		end
	end
	a_mac_port_isolation_quiet: assert property (!mac_rx_oe |-> mac_rxd == 4'h0 && !mac_rx_dv && !tx_en_out)
		else $error("MAC side outputs active while isolated");
	a_rx_pass: assert property (mac_rx_oe && $past(mac_rx_oe) |->
		mac_rxd == $past(rx_nibble_in) && mac_rx_dv == $past(rx_dv_in))
		else $error("receive pins do not follow the core");
	a_irq_clear: assert property ($fell(irq) |-> since_wr <= 4'h5)
		else $error("event interrupt dropped without a write");
	a_gen_raise: assert property ($fell(general_phy_irq_out) |-> since_ev <= 4'h5 || since_wr <= 4'h5)
		else $error("general interrupt without a cause");
	a_gen_clear: assert property ($rose(general_phy_irq_out) |-> since_ev <= 4'h5 || since_wr <= 4'h5)
		else $error("general interrupt released without access");
	a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_awready ##1 s_axi_bvalid)
		else $error("write answer late");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer withdrawn");
	a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer withdrawn");
	c_wake: cover property ($fell(first_led_pin));
	c_general: cover property ($fell(general_phy_irq_out));
	c_mac_port_isolation: cover property ($fell(mac_rx_oe));
endmodule

bind wfd_top wfd_chk #(.AW(AW)) u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_frame_end,
	.rx_nibble_in, .rx_dv_in, .mac_rxd, .mac_rx_dv, .mac_rx_oe, .tx_en_out, .first_led_pin,
	.general_phy_irq_out, .irq);

/* test/wfd_mac_model.sv */
// Far side model: received byte stream and MAC pin traffic
`timescale 1ns/1ps
module wfd_mac_model #(
	parameter logic [47:0] NODE = 48'h665544332211
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, low
	output logic rx_byte_valid, // Byte strobe
	output logic [7:0] rx_byte, // Byte
	output logic rx_frame_end, // Frame end
	output logic rx_crc_ok, // Check result
	output logic [3:0] rx_nibble_in, // Rx nibble
	output logic rx_dv_in, // Rx valid
	output logic [3:0] mac_txd, // Tx nibble
	output logic mac_tx_en // Tx enable
);
	logic [3:0] cnt = 4'h0;
	initial begin
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		rx_frame_end = 1'b0;
		rx_crc_ok = 1'b0;
	end
	// Pins never sit still, so isolation has traffic to hide
	always @(posedge aclk) begin
		cnt <= aresetn ? cnt + 4'h1 : 4'h0;
		rx_nibble_in <= cnt;
		rx_dv_in <= cnt[1];
		mac_txd <= ~cnt;
		mac_tx_en <= cnt[2];
	end
	// Frame of filler, sync run, address copies and padding; gap slows the byte rate
	task automatic send_frame(input int reps, input logic crc, input int gap);
		logic [7:0] q[$];
		q = '{8'h12, 8'hFE};
		repeat (6) q.push_back(8'hFF);
		repeat (reps) for (int k = 0; k < 6; k++) q.push_back(NODE[8*k +: 8]);
		while (q.size() < 70) q.push_back(8'h00);
		foreach (q[i]) begin
			@(posedge aclk);
			rx_byte_valid <= 1'b1;
			rx_byte <= q[i];
			repeat (gap) begin
				@(posedge aclk);
				rx_byte_valid <= 1'b0;
				rx_byte <= ~q[i];
			end
		end
		@(posedge aclk);
		rx_byte_valid <= 1'b0;
		rx_byte <= 8'h5A;
		rx_frame_end <= 1'b1;
		rx_crc_ok <= crc;
		@(posedge aclk);
		rx_frame_end <= 1'b0;
		rx_crc_ok <= ~crc;
	endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench of the wake frame detector
`timescale 1ns/1ps
module tb_top;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [17:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] s_axi_wstrb, rx_nibble_in, mac_rxd, mac_txd, tx_nibble_out;
	logic rx_byte_valid, rx_frame_end, rx_crc_ok, rx_dv_in, mac_rx_dv, mac_rx_oe, mac_tx_en;
	logic [7:0] rx_byte;
	logic tx_en_out, wake_strap_pad, led_state_in, first_led_pin, general_phy_irq_out, irq;
	int num_errors, checks_done, cycles;
	localparam logic [1:0] OK = wfd_pkg::RESP_OKAY;
	logic [15:0] regs [10] = '{wfd_pkg::IDX_BASIC_CONTROL, wfd_pkg::IDX_INT_ENABLE,
		wfd_pkg::IDX_INT_STATUS, wfd_pkg::IDX_WAKE_CONTROL, wfd_pkg::IDX_WAKE_MODE,
		wfd_pkg::IDX_ADDR_LOW, wfd_pkg::IDX_ADDR_MID, wfd_pkg::IDX_ADDR_HIGH,
		wfd_pkg::IDX_EVT_STATUS, wfd_pkg::IDX_EVT_MASK};
	wfd_top #(.AW(18)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .rx_byte_valid, .rx_byte, .rx_frame_end, .rx_crc_ok,
		.rx_nibble_in, .rx_dv_in, .mac_rxd, .mac_rx_dv, .mac_rx_oe, .mac_txd, .mac_tx_en,
		.tx_nibble_out, .tx_en_out, .wake_strap_pad, .led_state_in, .first_led_pin,
		.general_phy_irq_out, .irq);
	wfd_mac_model mac (.aclk, .aresetn, .rx_byte_valid, .rx_byte, .rx_frame_end, .rx_crc_ok,
		.rx_nibble_in, .rx_dv_in, .mac_txd, .mac_tx_en);
	always #4 aclk = ~aclk;
	// Hang guard, far above the fewer than 1500 cycles the sequence needs
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic pin(input string name, input logic seen, input logic exp);
		chk(name, {31'h0, seen}, {31'h0, exp});
	endtask
	// Ready is raised only once the answer shows, so the slave must hold it
	task automatic wr(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] re);
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00};
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= {16'h0000, d};
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
		end while (!(s_axi_bvalid && s_axi_bready));
		s_axi_bready <= 1'b0;
		chk("bresp", {30'h0, s_axi_bresp}, {30'h0, re});
	endtask
	task automatic rd(input logic [15:0] idx, input logic [15:0] e, input logic [1:0] re);
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
		end while (!(s_axi_rvalid && s_axi_rready));
		s_axi_rready <= 1'b0;
		chk("rdata", s_axi_rdata, {16'h0000, e});
		chk("rresp", {30'h0, s_axi_rresp}, {30'h0, re});
	endtask
	// Low phase of the wake output, counted in clock cycles
	task automatic pulse_len(input int exp);
		int n;
		n = 0;
		while (first_led_pin !== 1'b0 && n < 64) begin
			@(posedge aclk);
			n++;
		end
		n = 0;
		while (first_led_pin === 1'b0 && n < 200) begin
			n++;
			@(posedge aclk);
		end
		chk("pulse width", 32'(n), 32'(exp));
	endtask
	initial begin
		{aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		wake_strap_pad = 1'b1;
		led_state_in = 1'b1;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (8) @(posedge aclk);
		foreach (regs[i]) rd(regs[i], 16'h0000, OK);
		rd(16'h0100, 16'h0000, wfd_pkg::RESP_SLVERR);
		wr(16'h0100, 16'h1234, wfd_pkg::RESP_SLVERR);
		wr(wfd_pkg::IDX_INT_STATUS, 16'hFFFF, OK);
		for (int i = 0; i < 3; i++) begin
			wr(wfd_pkg::IDX_ADDR_LOW + 16'(i), 16'h2211 + 16'(i) * 16'h2222, OK);
			rd(wfd_pkg::IDX_ADDR_LOW + 16'(i), 16'h2211 + 16'(i) * 16'h2222, OK);
		end
		wr(wfd_pkg::IDX_INT_ENABLE, 16'h0040, OK);
		mac.send_frame(16, 1'b1, 0);
		repeat (6) @(posedge aclk);
		rd(wfd_pkg::IDX_INT_STATUS, 16'h0000, OK);
		wr(wfd_pkg::IDX_WAKE_CONTROL, 16'h0004, OK);
		mac.send_frame(15, 1'b1, 0);
		repeat (6) @(posedge aclk);
		rd(wfd_pkg::IDX_INT_STATUS, 16'h0000, OK);
		mac.send_frame(16, 1'b0, 0);
		repeat (6) @(posedge aclk);
		rd(wfd_pkg::IDX_INT_STATUS, 16'h0000, OK);
		rd(wfd_pkg::IDX_EVT_STATUS, 16'h0002, OK);
		wr(wfd_pkg::IDX_EVT_STATUS, 16'h0002, OK);
		// Slow byte rate, level mode
		mac.send_frame(16, 1'b1, 1);
		repeat (6) @(posedge aclk);
		pin("wake level", first_led_pin, 1'b0);
		pin("general irq", general_phy_irq_out, 1'b0);
		rd(wfd_pkg::IDX_INT_STATUS, 16'h0040, OK);
		wr(wfd_pkg::IDX_EVT_MASK, 16'h0001, OK);
		repeat (3) @(posedge aclk);
		pin("irq", irq, 1'b1);
		wr(wfd_pkg::IDX_EVT_STATUS, 16'h0001, OK);
		repeat (3) @(posedge aclk);
		pin("irq", irq, 1'b0);
		pin("general irq", general_phy_irq_out, 1'b0);
		wr(wfd_pkg::IDX_WAKE_CONTROL, 16'h0000, OK);
		repeat (4) @(posedge aclk);
		pin("wake level", first_led_pin, 1'b1);
		wr(wfd_pkg::IDX_WAKE_CONTROL, 16'h0004, OK);
		// pulse mode chosen so status reads clear the general interrupt
		for (int s = 0; s < 4; s++) begin
			wr(wfd_pkg::IDX_WAKE_MODE, 16'h0080 | 16'(s << 8), OK);
			mac.send_frame(16, 1'b1, 0);
			pulse_len(8 << s);
			pin("general irq", general_phy_irq_out, 1'b0);
			rd(wfd_pkg::IDX_INT_STATUS, 16'h0040, OK);
			repeat (3) @(posedge aclk);
			pin("general irq", general_phy_irq_out, 1'b1);
		end
		// power-down bit stays clear in every control write
		wr(wfd_pkg::IDX_BASIC_CONTROL, 16'h0400, OK);
		repeat (2) @(posedge aclk);
		pin("rx enable", mac_rx_oe, 1'b0);
		chk("rxd", {mac_rx_dv, tx_en_out, mac_rxd, tx_nibble_out}, 32'h0);
		rd(wfd_pkg::IDX_BASIC_CONTROL, 16'h0400, OK);
		wr(wfd_pkg::IDX_BASIC_CONTROL, 16'h0000, OK);
		repeat (2) @(posedge aclk);
		pin("rx enable", mac_rx_oe, 1'b1);
		// Second reset with the strap low: pin takes its LED role, registers back to zero
		wake_strap_pad <= 1'b0;
		aresetn <= 1'b0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (6) @(posedge aclk);
		rd(wfd_pkg::IDX_WAKE_CONTROL, 16'h0000, OK);
		pin("led role", first_led_pin, 1'b1);
		led_state_in <= 1'b0;
		repeat (2) @(posedge aclk);
		pin("led role", first_led_pin, 1'b0);
		report_and_stop();
	end
endmodule
